// ---- hw/wbs_pkg.sv ----
// constants, types and register map for the write buffer slice
package wbs_pkg;

  // ********************************
  // sizes
  // ********************************
  localparam int WBS_ENTRIES    = 4;
  localparam int WBS_FIFO_DEPTH = 16;
  localparam int WBS_SYNC_STAGES = 2;

  // ********************************
  // register map
  // ********************************
  localparam logic [31:0] WBS_CTRL_OFF   = 32'h0000_0000;
  localparam logic [31:0] WBS_STAT_OFF   = 32'h0000_0004;
  localparam logic [3:0]  WBS_CTRL_RST   = 4'h1;
  localparam int          WBS_CTRL_EN_BIT  = 0;
  localparam int          WBS_CTRL_SLOT_LO = 1;
  localparam int          WBS_CTRL_END_BIT = 3;
  localparam int          WBS_STAT_FULL_BIT = 3;
  localparam int          WBS_STAT_REQ_BIT  = 4;
  localparam int          WBS_STAT_OVR_BIT  = 8;
  localparam logic [2:0]  WBS_COUNT_RST  = 3'h0;
  localparam logic [1:0]  WBS_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  WBS_RESP_SLVERR = 2'h2;

  // ********************************
  // access size codes
  // ********************************
  localparam logic [1:0] WBS_SIZE_BYTE = 2'h0;
  localparam logic [1:0] WBS_SIZE_HALF = 2'h1;
  localparam logic [1:0] WBS_SIZE_TRI  = 2'h2;
  localparam logic [1:0] WBS_SIZE_WORD = 2'h3;

  // ********************************
  // types
  // ********************************
  typedef struct packed {
    logic [7:0] addr;
    logic [8:0] data;
    logic [1:0] size;
    logic       lane;
  } wbs_entry_t;

  localparam int WBS_ENTRY_W = $bits(wbs_entry_t);

  typedef struct packed {
    logic       phase_clk;
    logic       strobe;
    logic [1:0] byte_sel;
    logic [1:0] size;
    logic [7:0] addr;
    logic [8:0] data;
    logic       drive_en;
    logic       ack;
  } wbs_pins_t;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_LOW  = 2'h1,
    CAP_PUSH = 2'h3
  } wbs_cap_t;

endpackage : wbs_pkg

// ---- hw/wbs_mem.sv ----
// small storage array with registered read data
`timescale 1ns/10ps
module wbs_mem #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_clock,
  input  wire logic             i_clock_en,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_rd_en,
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] store_q [DEPTH];

  // no reset on the array; entries are only read after a write
  always_ff @(posedge i_clock) begin
    if (i_clock_en && i_wr_en) begin
      store_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_clock_en && i_rd_en) begin
      o_rd_data <= store_q[i_rd_addr];
    end
  end

endmodule : wbs_mem

// ---- hw/wbs_fifo.sv ----
// first-in first-out queue around the storage array
`timescale 1ns/10ps
module wbs_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_clock_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int         AW     = $clog2(DEPTH);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);

  logic [AW:0]   cnt_q;
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic          out_v_q;
  logic          wr;
  logic          rd;

  assign o_in_ready  = (cnt_q != FULL_C);
  assign wr          = i_in_valid && o_in_ready;
  // array read only when the output stage is free or draining
  assign rd          = (cnt_q != '0) && (!out_v_q || i_out_ready);
  assign o_out_valid = out_v_q;

  wbs_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .i_clock    (i_clock),
    .i_clock_en (i_clock_en),
    .i_wr_en    (wr),
    .i_wr_addr  (wr_q),
    .i_wr_data  (i_in_data),
    .i_rd_en    (rd),
    .i_rd_addr  (rd_q),
    .o_rd_data  (o_out_data)
  );

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_clock_en) begin
      if (wr) begin
        wr_q <= wr_q + 1'b1;
      end
      if (rd) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else if (i_clock_en) begin
      case ({wr, rd})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      out_v_q <= 1'b0;
    end else if (i_clock_en) begin
      if (rd) begin
        out_v_q <= 1'b1;
      end else if (i_out_ready) begin
        out_v_q <= 1'b0;
      end
    end
  end

endmodule : wbs_fifo

// ---- hw/wbs_top.sv ----
// one byte-lane slice of a four-entry posted write buffer
`timescale 1ns/10ps
module wbs_top
  import wbs_pkg::*;
#(
  parameter int ENTRIES    = WBS_ENTRIES,
  parameter int FIFO_DEPTH = WBS_FIFO_DEPTH
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_clock_en,
  input  wire logic        i_cpu_phase_clock,
  input  wire logic        i_store_strobe_in,
  input  wire logic [1:0]  i_byte_select_bits,
  input  wire logic [1:0]  i_size_code_in,
  input  wire logic [7:0]  i_address_slice_in,
  input  wire logic [8:0]  i_data_slice_in,
  input  wire logic        i_output_drive_enable,
  input  wire logic        i_mem_acknowledge,
  output logic             o_buffer_full_flag,
  output logic             o_mem_request,
  output logic [7:0]       o_address_slice_out,
  output logic [8:0]       o_data_slice_out,
  output logic [1:0]       o_size_code_out,
  output logic             o_lane_active,
  output logic             o_out_oe,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  // ********************************
  // functions
  // ********************************
  // 2'h1 control, 2'h2 status, 2'h0 unmapped
  function automatic logic [1:0] reg_sel(input logic [31:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr == WBS_CTRL_OFF) begin
      sel = 2'h1;
    end else if (addr == WBS_STAT_OFF) begin
      sel = 2'h2;
    end
    return sel;
  endfunction : reg_sel

  // does the store touch this slice's byte lane
  function automatic logic lane_hit(input logic [1:0] bsel,
                                    input logic [1:0] size,
                                    input logic [1:0] slot,
                                    input logic       big);
    logic [1:0] lane;
    logic [2:0] last;
    lane = big ? ~slot : slot;
    last = {1'b0, bsel} + {1'b0, size};
    return (lane >= bsel) && ({1'b0, lane} <= last);
  endfunction : lane_hit

  localparam logic [2:0] ENTRIES_C = 3'(ENTRIES);

  // ********************************
  // pin synchronisers
  // ********************************
  // idle pin levels, so leaving reset makes no false phase edge
  localparam wbs_pins_t PINS_IDLE = '{phase_clk: 1'b1, default: '0};

  wbs_pins_t pins_raw;
  wbs_pins_t meta_q;
  wbs_pins_t sync_q;
  wbs_pins_t prev_q;
  logic      fall;
  logic      rise;
  logic      ack_rise;

  assign pins_raw = '{phase_clk: i_cpu_phase_clock,
                      strobe:    i_store_strobe_in,
                      byte_sel:  i_byte_select_bits,
                      size:      i_size_code_in,
                      addr:      i_address_slice_in,
                      data:      i_data_slice_in,
                      drive_en:  i_output_drive_enable,
                      ack:       i_mem_acknowledge};

  // phase clock is sampled, not used as a clock; needs 4+ samples per half
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else if (i_clock_en) begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign fall     = prev_q.phase_clk && !sync_q.phase_clk;
  assign rise     = !prev_q.phase_clk && sync_q.phase_clk;
  assign ack_rise = sync_q.ack && !prev_q.ack;

  // ********************************
  // control register fields
  // ********************************
  logic [3:0] ctrl_q;
  logic       cap_en;
  logic [1:0] slot;
  logic       big_end;

  assign cap_en  = ctrl_q[WBS_CTRL_EN_BIT];
  assign slot    = ctrl_q[WBS_CTRL_SLOT_LO +: 2];
  assign big_end = ctrl_q[WBS_CTRL_END_BIT];

  // ********************************
  // processor capture
  // ********************************
  wbs_cap_t   cap_q;
  logic [3:0] low_addr_q;
  logic [1:0] bsel_q;
  wbs_entry_t entry_q;
  logic       store_seen;
  logic       accept;
  logic       push;
  logic       fifo_in_ready;
  logic       full_q;

  assign store_seen = fall && sync_q.strobe && cap_en;
  // a store while full or mid-capture is refused, never overwrites
  assign accept     = store_seen && !full_q && (cap_q == CAP_IDLE);
  assign push       = (cap_q == CAP_PUSH) && fifo_in_ready;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cap_q <= CAP_IDLE;
    end else if (i_clock_en) begin
      case (cap_q)
        CAP_IDLE: begin
          if (accept) begin
            cap_q <= CAP_LOW;
          end
        end
        CAP_LOW: begin
          if (rise) begin
            cap_q <= CAP_PUSH;
          end
        end
        CAP_PUSH: begin
          if (fifo_in_ready) begin
            cap_q <= CAP_IDLE;
          end
        end
        default: cap_q <= CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      low_addr_q <= 4'h0;
      bsel_q     <= 2'h0;
    end else if (i_clock_en && accept) begin
      low_addr_q <= sync_q.addr[3:0];
      bsel_q     <= sync_q.byte_sel;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      entry_q <= '0;
    end else if (i_clock_en && (cap_q == CAP_LOW) && rise) begin
      entry_q.addr <= {sync_q.addr[7:4], low_addr_q};
      entry_q.data <= sync_q.data;
      entry_q.size <= sync_q.size;
      entry_q.lane <= lane_hit(bsel_q, sync_q.size, slot, big_end);
    end
  end

  // ********************************
  // queue and presented entry
  // ********************************
  wbs_entry_t fifo_out;
  wbs_entry_t pres_q;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic       pres_valid_q;
  logic       retire;
  logic       pop;

  // entry width fixes the slice; four in parallel make the full word
  wbs_fifo #(.WIDTH(WBS_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_clock_en  (i_clock_en),
    .i_in_valid  (cap_q == CAP_PUSH),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (entry_q),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out)
  );

  assign retire         = ack_rise && pres_valid_q;
  assign fifo_out_ready = !pres_valid_q || retire;
  assign pop            = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pres_valid_q <= 1'b0;
      pres_q       <= '0;
    end else if (i_clock_en) begin
      if (pop) begin
        pres_valid_q <= 1'b1;
        pres_q       <= fifo_out;
      end else if (retire) begin
        pres_valid_q <= 1'b0;
      end
    end
  end

  // ********************************
  // occupancy, full and request
  // ********************************
  logic [2:0] occ_q;
  logic [2:0] occ_d;
  logic [2:0] buf_q;
  logic [2:0] buf_d;
  logic       req_q;
  logic       oe_q;

  // occ counts from acceptance so full covers the store in flight
  always_comb begin
    occ_d = occ_q;
    buf_d = buf_q;
    if (accept && !retire) begin
      occ_d = occ_q + 3'h1;
    end else if (retire && !accept) begin
      occ_d = occ_q - 3'h1;
    end
    if (push && !retire) begin
      buf_d = buf_q + 3'h1;
    end else if (retire && !push) begin
      buf_d = buf_q - 3'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      occ_q  <= WBS_COUNT_RST;
      buf_q  <= WBS_COUNT_RST;
      full_q <= 1'b0;
      req_q  <= 1'b0;
    end else if (i_clock_en) begin
      occ_q  <= occ_d;
      buf_q  <= buf_d;
      full_q <= (occ_d >= ENTRIES_C) || !fifo_in_ready;
      req_q  <= (buf_d != 3'h0);
    end
  end

  // outputs stay stable; the wire resolves them only while oe is high
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      oe_q <= 1'b0;
    end else if (i_clock_en) begin
      oe_q <= sync_q.drive_en && pres_valid_q;
    end
  end

  assign o_buffer_full_flag  = full_q;
  assign o_mem_request       = req_q;
  assign o_out_oe            = oe_q;
  assign o_address_slice_out = pres_q.addr;
  assign o_data_slice_out    = pres_q.data;
  assign o_size_code_out     = pres_q.size;
  assign o_lane_active       = pres_q.lane;

  // ********************************
  // lost store flag
  // ********************************
  logic ovr_q;
  logic ovr_clr;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ovr_q <= 1'b0;
    end else if (i_clock_en) begin
      if (store_seen && !accept) begin
        ovr_q <= 1'b1; // set beats a same-cycle clear
      end else if (ovr_clr) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // ********************************
  // register bus slave
  // ********************************
  logic        awready_q;
  logic        wready_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] stat_word;
  logic        do_write;
  logic [1:0]  wsel;
  logic [1:0]  rsel;

  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign wsel     = reg_sel(awaddr_q);
  assign rsel     = reg_sel(i_s_axi_araddr);
  assign ovr_clr  = do_write && (wsel == 2'h2) && wstrb_q[1]
                    && wdata_q[WBS_STAT_OVR_BIT];

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[2:0] = occ_q;
    stat_word[WBS_STAT_FULL_BIT] = full_q;
    stat_word[WBS_STAT_REQ_BIT]  = req_q;
    stat_word[WBS_STAT_OVR_BIT]  = ovr_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (i_clock_en) begin
      if (i_s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_got_q  <= 1'b1;
        awaddr_q  <= i_s_axi_awaddr;
      end else if (do_write) begin
        aw_got_q <= 1'b0;
      end else if (bvalid_q && i_s_axi_bready) begin
        awready_q <= 1'b1;
      end
      if (i_s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
      end else if (do_write) begin
        w_got_q <= 1'b0;
      end else if (bvalid_q && i_s_axi_bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= WBS_RESP_OKAY;
    end else if (i_clock_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wsel == 2'h0) ? WBS_RESP_SLVERR : WBS_RESP_OKAY;
      end else if (i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_q <= WBS_CTRL_RST;
    end else if (i_clock_en && do_write && (wsel == 2'h1)
                 && wstrb_q[0]) begin
      ctrl_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= WBS_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (i_clock_en) begin
      if (i_s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        case (rsel)
          2'h1: begin
            rdata_q <= {28'h0000000, ctrl_q};
            rresp_q <= WBS_RESP_OKAY;
          end
          2'h2: begin
            rdata_q <= stat_word;
            rresp_q <= WBS_RESP_OKAY;
          end
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= WBS_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && i_s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_s_axi_rdata   = rdata_q;

  // ********************************
  // checks
  // ********************************
  a_depth_bound:
    assert property (@(posedge i_clock) disable iff (i_reset)
      occ_q <= ENTRIES_C)
    else $error("occupancy above entry count");

  a_full_at_limit:
    assert property (@(posedge i_clock) disable iff (i_reset)
      (i_clock_en && occ_d >= ENTRIES_C) |=> o_buffer_full_flag)
    else $error("full flag missing at last entry");

  a_no_overwrite:
    assert property (@(posedge i_clock) disable iff (i_reset)
      accept |-> !full_q && (occ_q < ENTRIES_C))
    else $error("store taken while full");

  a_low_on_fall:
    assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(cap_q == CAP_LOW) |-> $past(fall && sync_q.strobe))
    else $error("low address not taken on falling edge");

  a_data_on_rise:
    assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(cap_q == CAP_PUSH) |-> $past(rise)
        && entry_q.data == $past(sync_q.data))
    else $error("data not taken on rising edge");

  a_req_when_held:
    assert property (@(posedge i_clock) disable iff (i_reset)
      (i_clock_en && pres_valid_q && !retire) |=> o_mem_request)
    else $error("request low while pair waits");

  a_req_drop_cause:
    assert property (@(posedge i_clock) disable iff (i_reset)
      $fell(o_mem_request) |-> $past(retire) && buf_q == 3'h0)
    else $error("request dropped without last acknowledge");

  a_req_empty:
    assert property (@(posedge i_clock) disable iff (i_reset)
      (buf_q == 3'h0 && !$past(push)) |-> !o_mem_request)
    else $error("request high with empty buffer");

  a_retire_step:
    assert property (@(posedge i_clock) disable iff (i_reset)
      (i_clock_en && retire && !push) |=> buf_q == $past(buf_q) - 3'h1)
    else $error("acknowledge did not retire entry");

  a_oe_needs_entry:
    assert property (@(posedge i_clock) disable iff (i_reset)
      o_out_oe |-> $past(pres_valid_q) && $past(sync_q.drive_en))
    else $error("outputs driven without enable or entry");

endmodule : wbs_top

// ---- dv/wbs_partner.sv ----
// processor and memory controller model beside one buffer slice
`timescale 1ns/10ps
module wbs_partner
  import wbs_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_full,
  input  wire logic       i_oe,
  input  wire wbs_entry_t i_entry,
  output logic            o_phase,
  output logic            o_strobe,
  output logic [1:0]      o_byte_sel,
  output logic [1:0]      o_size,
  output logic [7:0]      o_addr,
  output logic [8:0]      o_data,
  output logic            o_drive_en,
  output logic            o_ack
);
  initial begin
    {o_strobe, o_byte_sel, o_size, o_addr, o_data} = '0;
    {o_phase, o_drive_en, o_ack} = 3'h4;
  end
  // halves of 8 cycles, twice the minimum; stale data, byte select and high address lanes carry inverses, size keeps its old value
  task automatic store(input logic [7:0] a, input logic [8:0] d,
                       input logic [1:0] sz, bs, input logic stall);
    @(posedge i_clock);
    while (stall && i_full) @(posedge i_clock);
    o_strobe   <= 1'b1;
    o_byte_sel <= bs;
    o_addr     <= {~a[7:4], a[3:0]};
    o_data     <= ~d;
    o_phase    <= 1'b0;
    repeat (8) @(posedge i_clock);
    o_byte_sel <= ~bs;
    o_addr     <= a;
    o_data     <= d;
    o_size     <= sz;
    o_phase    <= 1'b1;
    repeat (8) @(posedge i_clock);
    o_strobe <= 1'b0;
    o_addr   <= ~a;
    o_data   <= ~d;
  endtask : store
  task automatic fetch(output wbs_entry_t e);
    @(posedge i_clock);
    o_drive_en <= 1'b1;
    do @(posedge i_clock); while (!i_oe);
    e = i_entry;
    o_ack <= 1'b1;
    repeat (6) @(posedge i_clock);
    {o_ack, o_drive_en} <= 2'h0;
    repeat (6) @(posedge i_clock);
  endtask : fetch
endmodule : wbs_partner

// ---- dv/tb_top.sv ----
// self-checking bench for the write buffer slice
`timescale 1ns/10ps
module tb_top
  import wbs_pkg::*;
;
  logic        clk, rst, awv, wv, bre, arv, rre;
  logic [31:0] awa, wd, ara;
  logic [3:0]  ws;
  logic [2:0]  pr;
  wire         awr, wr, bv, arr, rv, full, req, oe, ph, stb, den, ack;
  wire [1:0]   br, rr, bs, sz;
  wire [31:0]  rd;
  wire [7:0]   ad;
  wire [8:0]   dt;
  wire wbs_entry_t ent;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  wbs_top uut (
    .i_clock(clk), .i_reset(rst), .i_clock_en(1'b1),
    .i_cpu_phase_clock(ph), .i_store_strobe_in(stb),
    .i_byte_select_bits(bs), .i_size_code_in(sz),
    .i_address_slice_in(ad), .i_data_slice_in(dt),
    .i_output_drive_enable(den), .i_mem_acknowledge(ack),
    .o_buffer_full_flag(full), .o_mem_request(req), .o_out_oe(oe),
    .o_address_slice_out(ent.addr), .o_data_slice_out(ent.data),
    .o_size_code_out(ent.size), .o_lane_active(ent.lane),
    .i_s_axi_awaddr(awa), .i_s_axi_awprot(pr), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
    .i_s_axi_arprot(pr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rre));
  wbs_partner p (
    .i_clock(clk), .i_full(full), .i_oe(oe), .i_entry(ent),
    .o_phase(ph), .o_strobe(stb), .o_byte_sel(bs), .o_size(sz),
    .o_addr(ad), .o_data(dt), .o_drive_en(den), .o_ack(ack));
  task automatic chk(input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    {awv, wv, bre} <= 3'h7;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    r = br;
    bre <= 1'b0;
  endtask : axw
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    {d, r} = {rd, rr};
    rre <= 1'b0;
  endtask : axr
  task automatic s_fill();
    logic [31:0] d;
    logic [1:0]  r;
    wbs_entry_t  e;
    chk(32'({req, full, oe}), 32'h0);
    axr(WBS_CTRL_OFF, d, r);
    chk(d, 32'h1);
    for (int i = 0; i < 4; i++)
      p.store(8'h10 + 8'(i), 9'h1a5 ^ 9'(i), 2'(i), 2'h0, 1'b0);
    chk(32'({full, req}), 32'h3);
    // lost store: must not overwrite any queued entry
    p.store(8'hee, 9'h0ee, 2'h3, 2'h0, 1'b0);
    axr(WBS_STAT_OFF, d, r);
    chk(d, 32'h11c);
    axw(WBS_STAT_OFF, 32'h100, r);
    axr(WBS_STAT_OFF, d, r);
    chk(d, 32'h1c);
    for (int i = 0; i < 4; i++) begin
      p.fetch(e);
      chk(32'(e), 32'({8'h10 + 8'(i), 9'h1a5 ^ 9'(i), 2'(i), 1'b1}));
      chk(32'(req), 32'(i < 3));
    end
    chk(32'(full), 32'h0);
  endtask : s_fill
  task automatic s_lane();
    logic [31:0] d;
    logic [1:0]  r;
    wbs_entry_t  e;
    axw(WBS_CTRL_OFF, 32'hb, r);
    axr(WBS_CTRL_OFF, d, r);
    chk(d, 32'hb);
    p.store(8'h31, 9'h012, WBS_SIZE_BYTE, 2'h1, 1'b1);
    p.store(8'h32, 9'h134, WBS_SIZE_HALF, 2'h1, 1'b1);
    p.fetch(e);
    chk(32'(e.lane), 32'h0);
    p.fetch(e);
    chk(32'(e), 32'({8'h32, 9'h134, WBS_SIZE_HALF, 1'b1}));
    chk(32'(req), 32'h0);
    axw(32'h40, 32'h0, r);
    chk(32'(r), 32'(WBS_RESP_SLVERR));
    axr(32'h40, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(WBS_RESP_SLVERR));
  endtask : s_lane
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {rst, awv, wv, bre, arv, rre} = 6'h20;
    {awa, wd, ara, pr} = '0;
    ws = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_fill();
    s_lane();
    close_out();
  end
endmodule : tb_top
